/* hdl/ssa_arbiter.sv */
/*
 * slave-side share arbiter: one arbiter in front of one shared slave port,
 * fed by N_MASTERS master ports. picks a master by round-robin with share
 * counts, stalls losers through their wait-request, muxes the winner onto
 * the slave and holds the grant for the length of a burst, splitting long
 * master bursts into slave-sized bursts.
 * assumes: one clock, synchronous active-low reset, masters on the same
 * clock; the slave accepts a beat in the cycle its wait-request is low and
 * returns read data in that same cycle.
 */
// Contract
// - stall master only on same-slave contention
// - other slaves reached without this arbiter
// - mux granted master's signals to slave
// - decode each master's request every cycle
// - no requester means nobody connected
// - winner proceeds, other requesters see wait
// - each share allows one transfer
// - back-to-back transfers up to share count
// - dropped request forfeits remaining shares
// - regained grant gets full shares
// - turns handed out round-robin
// - round-robin skips idle masters
// - burst locks slave to its master
// - share is max of minimum and configured
// - burst slaves ignore minimum share
// - per-port burst limits, long bursts handled
// - long burst split into maximum-length slave bursts
// - non-burst slave gets one transfer per beat
// - lock held until whole master burst ends
`timescale 1ns/1ps

module ssa_arbiter #(
   parameter int N_MASTERS = 2,
   // one share count per master, master 0 in the low byte
   parameter logic [N_MASTERS*ssa_pkg::SHARE_W-1:0] SHARES = {8'h04, 8'h03},
   // minimum share declared by the slave; 1 means no minimum
   parameter logic [ssa_pkg::SHARE_W-1:0] MIN_SHARE = 8'h01,
   // longest slave burst; 1 means the slave has no burst support
   parameter logic [ssa_pkg::BC_W-1:0] SLV_MAX_BURST = 5'h08,
   // address window of this slave
   parameter logic [ssa_pkg::ADDR_W-1:0] SLV_BASE = 32'h00000000,
   parameter logic [ssa_pkg::ADDR_W-1:0] SLV_MASK = 32'h00000000
) (
   input wire logic clk,
   input wire logic rst_b,
   input ssa_pkg::ssa_cmd_type m_cmd [N_MASTERS],
   output logic [N_MASTERS-1:0] m_waitrequest,
   output logic [N_MASTERS-1:0] m_readvalid,
   output logic [ssa_pkg::DATA_W-1:0] m_readdata,
   output ssa_pkg::ssa_cmd_type s_cmd,
   input wire logic s_waitrequest,
   input wire logic [ssa_pkg::DATA_W-1:0] s_readdata,
   output logic grant_valid,
   output logic [$clog2(N_MASTERS > 1 ? N_MASTERS : 2)-1:0] grant_index,
   output logic burst_locked
);

   localparam int IDX_W = $clog2(N_MASTERS > 1 ? N_MASTERS : 2);
   localparam logic [IDX_W-1:0] IDX_ZERO = '0;
   localparam logic [IDX_W-1:0] IDX_LAST = IDX_W'(N_MASTERS - 1);
   // burst-capable slaves let the burst length govern, not the minimum
   localparam bit SLV_BURSTS = (SLV_MAX_BURST > ssa_pkg::BC_ONE);

   logic [N_MASTERS-1:0] req;
   logic [ssa_pkg::SHARE_W-1:0] eff_share [N_MASTERS];

   logic cur_valid;
   logic [IDX_W-1:0] cur;
   logic [IDX_W-1:0] rr_ptr;
   logic [ssa_pkg::SHARE_W-1:0] share_left;
   logic locked;
   logic [ssa_pkg::BC_W-1:0] burst_left;
   logic [ssa_pkg::BC_W-1:0] sub_left;
   logic [ssa_pkg::BC_W-1:0] sub_len;

   logic keep;
   logic found;
   logic [IDX_W-1:0] pick;
   logic gnt_valid;
   logic [IDX_W-1:0] gnt_idx;
   logic new_turn;
   logic xfer;
   logic [ssa_pkg::BC_W-1:0] total;
   logic [ssa_pkg::BC_W-1:0] sub_burst;
   logic new_sub;
   logic [ssa_pkg::SHARE_W-1:0] share_base;

   // per-master request decode and effective share
   genvar gi;
   generate
      for (gi = 0; gi < N_MASTERS; gi++) begin : g_master
         logic [ssa_pkg::SHARE_W-1:0] cfg;
         // a zero share would starve the master, so it counts as one
         assign cfg = (SHARES[gi*ssa_pkg::SHARE_W +: ssa_pkg::SHARE_W] == ssa_pkg::SHARE_ZERO)
                      ? ssa_pkg::SHARE_ONE
                      : SHARES[gi*ssa_pkg::SHARE_W +: ssa_pkg::SHARE_W];
         assign eff_share[gi] = (!SLV_BURSTS && (MIN_SHARE > cfg)) ? MIN_SHARE
                                : cfg;
         // a master asks for this slave only when its address hits our window
         assign req[gi] = (m_cmd[gi].read || m_cmd[gi].write)
                          && ((m_cmd[gi].address & SLV_MASK) == SLV_BASE);
         // losers stall; masters aimed elsewhere never see a wait from here
         assign m_waitrequest[gi] = req[gi]
                                    && !(gnt_valid && (gnt_idx == IDX_W'(gi)) && !s_waitrequest);
      end
   endgenerate

   // round-robin search from the pointer, idle masters passed over
   always_comb begin
      logic [IDX_W-1:0] idx;
      idx = rr_ptr;
      found = 1'b0;
      pick = IDX_ZERO;
      for (int k = 0; k < N_MASTERS; k++) begin
         if (!found && req[idx]) begin
            found = 1'b1;
            pick = idx;
         end
         idx = (idx == IDX_LAST) ? IDX_ZERO : idx + 1'b1;
      end
   end

   // the holder keeps the slave while locked, or while it asks and has shares
   assign keep = cur_valid && (locked || (req[cur] && (share_left != ssa_pkg::SHARE_ZERO)));
   // a gap in the holder's request drops it straight to the search unless locked; a locked holder's gap grants nobody
   assign gnt_valid = keep ? req[cur] : found;
   assign gnt_idx = keep ? cur : pick;
   assign new_turn = !keep && found;
   assign xfer = gnt_valid && !s_waitrequest;
   assign share_base = new_turn ? eff_share[pick] : share_left;

   // beats still owed by the master burst; zero count is taken as one beat
   assign total = locked ? burst_left
                  : ((m_cmd[gnt_idx].burstcount == ssa_pkg::BC_ZERO) ? ssa_pkg::BC_ONE
                     : m_cmd[gnt_idx].burstcount);
   assign new_sub = (sub_left == ssa_pkg::BC_ZERO);
   // slave bursts never exceed the slave limit; non-burst slaves get single beats
   assign sub_burst = (total > SLV_MAX_BURST) ? SLV_MAX_BURST : total;

   // slave side mux: nothing is driven toward the slave without a grant
   always_comb begin
      s_cmd = '0;
      if (gnt_valid) begin
         s_cmd = m_cmd[gnt_idx];
         s_cmd.burstcount = new_sub ? sub_burst : sub_len;
      end
   end

   // grant owner, round-robin pointer and share counter
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         cur_valid <= 1'b0;
         cur <= IDX_ZERO;
         rr_ptr <= IDX_ZERO;
         share_left <= eff_share[0];
      end else if (locked) begin
         cur_valid <= 1'b1; // burst beats do not spend shares
      end else if (gnt_valid) begin
         cur_valid <= 1'b1;
         cur <= gnt_idx;
         if (new_turn) begin
            rr_ptr <= (pick == IDX_LAST) ? IDX_ZERO : pick + 1'b1;
         end
         share_left <= xfer ? share_base - 1'b1 : share_base;
      end else begin
         cur_valid <= 1'b0; // released, so a return starts a fresh turn
      end
   end

   // burst tracking: lock for the whole master burst, split into slave bursts
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         locked <= 1'b0;
         burst_left <= ssa_pkg::BC_ZERO;
         sub_left <= ssa_pkg::BC_ZERO;
         sub_len <= ssa_pkg::BC_ONE;
      end else if (xfer) begin
         burst_left <= total - 1'b1;
         locked <= (total != ssa_pkg::BC_ONE);
         if (new_sub) begin
            sub_left <= sub_burst - 1'b1;
            sub_len <= sub_burst;
         end else begin
            sub_left <= sub_left - 1'b1;
         end
      end
   end

   // read data returned from flops, flagged to the master that asked
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         m_readvalid <= '0;
         m_readdata <= '0;
      end else begin
         for (int i = 0; i < N_MASTERS; i++) begin
            m_readvalid[i] <= xfer && (gnt_idx == IDX_W'(i)) && m_cmd[i].read;
         end
         if (xfer && s_cmd.read) begin
            m_readdata <= s_readdata;
         end
      end
   end

   // status view of the arbiter for software or debug
   assign grant_valid = gnt_valid;
   assign grant_index = gnt_idx;
   assign burst_locked = locked;

endmodule

/* hdl/ssa_pkg.sv */
/*
 * shared definitions for the slave-side share arbiter: bus widths,
 * the command carrier and the small constants used by the logic.
 * assumes every master and the slave use the same address and data widths.
 */
package ssa_pkg;

   localparam int ADDR_W = 32;
   localparam int DATA_W = 32;
   localparam int BC_W = 5;         // burst count, up to 31 beats
   localparam int SHARE_W = 8;      // share counter width

   localparam logic [BC_W-1:0] BC_ONE = 5'h01;
   localparam logic [BC_W-1:0] BC_ZERO = 5'h00;
   localparam logic [SHARE_W-1:0] SHARE_ONE = 8'h01;
   localparam logic [SHARE_W-1:0] SHARE_ZERO = 8'h00;

   // one transfer request as seen on a master or the slave port
   typedef struct packed {
      logic read;
      logic write;
      logic [ADDR_W-1:0] address;
      logic [DATA_W-1:0] writedata;
      logic [BC_W-1:0] burstcount;
   } ssa_cmd_type;

endpackage

/* tb/ssa_arbiter_asserts.sv */
/* port assertions for the share arbiter.
   assumes the default address window: every request targets this slave. */
`timescale 1ns/1ps
module ssa_arbiter_asserts #(
   parameter int N_MASTERS = 2,
   parameter logic [ssa_pkg::BC_W-1:0] SLV_MAX_BURST = 5'h08
) (
   input wire logic clk,
   input wire logic rst_b,
   input ssa_pkg::ssa_cmd_type m_cmd [N_MASTERS],
   input wire logic [N_MASTERS-1:0] m_waitrequest,
   input wire logic [N_MASTERS-1:0] m_readvalid,
   input wire logic [ssa_pkg::DATA_W-1:0] m_readdata,
   input ssa_pkg::ssa_cmd_type s_cmd,
   input wire logic s_waitrequest,
   input wire logic [ssa_pkg::DATA_W-1:0] s_readdata,
   input wire logic grant_valid,
   input wire logic [$clog2(N_MASTERS > 1 ? N_MASTERS : 2)-1:0] grant_index,
   input wire logic burst_locked
);
   logic [N_MASTERS-1:0] req;
   logic [N_MASTERS-1:0] acc;
   // who asks, and who is taken this cycle
   always_comb begin
      for (int i = 0; i < N_MASTERS; i++) begin
         req[i] = m_cmd[i].read | m_cmd[i].write;
         acc[i] = grant_valid && grant_index == i && !s_waitrequest;
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   a_idle_no_grant: assert property (req == '0 |-> !grant_valid && s_cmd == '0)
      else $error("grant with no request");
   a_grant_has_req: assert property (grant_valid |-> req[grant_index])
      else $error("grant to an idle master");
   a_mux_route: assert property (grant_valid |-> s_cmd.address == m_cmd[grant_index].address
      && s_cmd.writedata == m_cmd[grant_index].writedata) else $error("slave mux wrong");
   a_wait_losers: assert property (m_waitrequest == (req & ~acc))
      else $error("wait-request wrong");
   a_read_pulse: assert property (s_cmd.read && acc != '0 |=> m_readvalid == $past(acc)
      && m_readdata == $past(s_readdata)) else $error("read return wrong");
   a_no_stray_read: assert property (!(s_cmd.read && acc != '0) |=> m_readvalid == '0)
      else $error("read valid without a taken read");
   a_lock_owner: assert property (burst_locked && $past(grant_valid) |->
      !grant_valid || grant_index == $past(grant_index)) else $error("lock lost owner");
   a_split_len: assert property (grant_valid |-> s_cmd.burstcount inside {[1:SLV_MAX_BURST]})
      else $error("slave burst length out of range");
   a_reset_clear: assert property (disable iff (1'b0) !rst_b |=> !m_readvalid && !burst_locked)
      else $error("state not cleared by reset");
endmodule

/* tb/ssa_slave_model.sv */
/* shared slave model: ready every cycle or stalling every other cycle.
   assumes one command a cycle on s_cmd, read data in the accepting cycle. */
`timescale 1ns/1ps
module ssa_slave_model (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic slow,
   input ssa_pkg::ssa_cmd_type s_cmd,
   output logic s_waitrequest,
   output logic [ssa_pkg::DATA_W-1:0] s_readdata
);
   logic tog;
   logic [31:0] cyc;
   // stall phase cleared in reset so every run repeats exactly
   always_ff @(posedge clk) begin
      tog <= rst_b & ~tog;
      cyc <= rst_b ? cyc + 32'h1 : 32'h0;
   end
   assign s_waitrequest = slow & tog;
   // data only when a read is taken, a moving pattern otherwise
   assign s_readdata = (s_cmd.read & ~s_waitrequest) ? ~s_cmd.address : cyc;
endmodule

/* tb/tb_top.sv */
/* bench for the share arbiter: table-driven turns, gaps, bursts, stalls.
   assumes the slave model on the far side and a 40 MHz clock. */
`timescale 1ns/1ps
module tb_top;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic slow = 1'b0;
   ssa_pkg::ssa_cmd_type m_cmd [2] = '{default: '0};
   ssa_pkg::ssa_cmd_type s_cmd;
   logic [1:0] m_waitrequest, m_readvalid;
   logic [31:0] m_readdata, s_readdata;
   logic s_waitrequest, grant_valid, burst_locked;
   logic [0:0] grant_index;
   int err_total = 0;
   int n_compared = 0;
   always #12.5 clk = ~clk;
   ssa_arbiter ssa_arbiter_i (.clk(clk), .rst_b(rst_b), .m_cmd(m_cmd),
      .m_waitrequest(m_waitrequest), .m_readvalid(m_readvalid), .m_readdata(m_readdata),
      .s_cmd(s_cmd), .s_waitrequest(s_waitrequest), .s_readdata(s_readdata),
      .grant_valid(grant_valid), .grant_index(grant_index), .burst_locked(burst_locked));
   ssa_slave_model ssa_slave_model_i (.clk(clk), .rst_b(rst_b), .slow(slow), .s_cmd(s_cmd),
      .s_waitrequest(s_waitrequest), .s_readdata(s_readdata));
   task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         err_total++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic print_verdict();
      $display("compared %0d mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   // reset aborts whatever the masters were doing
   task automatic do_reset(logic s);
      @(posedge clk);
      rst_b <= 1'b0;
      slow <= s;
      m_cmd[0] <= '0;
      m_cmd[1] <= '0;
      repeat (16) @(posedge clk);
      rst_b <= 1'b1;
   endtask
   // per-cycle request patterns; exp holds the owner of each taken beat
   task automatic run(string name, logic [31:0] r0, logic [31:0] r1, logic [4:0] bc,
      logic rd, string exp);
      int b;
      int prev;
      int own;
      logic [1:0] rq;
      b = 0;
      prev = -1; // -1: no read taken last cycle, -2: owner not tabled
      for (int k = 0; k < 32; k++) begin
         @(posedge clk);
         // burst length shown with every beat, fixed non-sequential addresses
         m_cmd[0] <= '{rd & r0[k], !rd & r0[k], 32'h100, 32'ha5, bc};
         m_cmd[1] <= '{rd & r1[k], !rd & r1[k], 32'h200, 32'h5a, 5'h01};
         @(negedge clk);
         rq = {r1[k], r0[k]};
         if (prev != -2) chk("readvalid", m_readvalid, prev < 0 ? 0 : 2'b01 << prev);
         if (prev >= 0) chk("readdata", m_readdata, ~(32'h100 << prev));
         prev = -1;
         if (s_waitrequest) chk("stall wait", m_waitrequest, rq);
         if (grant_valid && !s_waitrequest && b < exp.len()) begin
            own = exp[b] - "0";
            chk(name, grant_index, own);
            chk("wait", m_waitrequest, rq & ~(2'b01 << own));
            chk("lock", burst_locked, bc == 5'h10 && b > 0 && b < 16);
            // only the long burst's first beats start a slave burst of the limit
            if (bc == 5'h10 && b < 16 && b % 8 == 0) chk("slave burst", s_cmd.burstcount, 8);
            if (rd) prev = own;
            b++;
         end else if (grant_valid && !s_waitrequest) begin
            prev = -2;
         end
      end
      $display("test %s done", name);
   endtask
   initial begin
      do_reset(1'b0);
      run("rotation", '1, '1, 5'h01, 1'b0, "0001111000111100011110");
      do_reset(1'b0);
      run("gap", ~32'h2, '1, 5'h01, 1'b0, "0111100011110");
      do_reset(1'b0);
      run("skip idle", '0, 32'hfff0ff0f, 5'h01, 1'b0, "1111111111");
      do_reset(1'b0);
      run("burst", 32'hffff, '1, 5'h10, 1'b0, "00000000000000001111");
      do_reset(1'b1);
      run("stall read", '1, '1, 5'h01, 1'b1, "0001111000");
      print_verdict();
   end
   // watchdog far beyond the few hundred cycles the tests need
   initial begin
      #50us;
      err_total++;
      print_verdict();
   end
endmodule
bind ssa_arbiter ssa_arbiter_asserts #(.N_MASTERS(N_MASTERS), .SLV_MAX_BURST(SLV_MAX_BURST))
   ssa_arbiter_asserts_i (.clk(clk), .rst_b(rst_b), .m_cmd(m_cmd),
   .m_waitrequest(m_waitrequest), .m_readvalid(m_readvalid), .m_readdata(m_readdata),
   .s_cmd(s_cmd), .s_waitrequest(s_waitrequest), .s_readdata(s_readdata),
   .grant_valid(grant_valid), .grant_index(grant_index), .burst_locked(burst_locked));
